//--- bench/udtst_cmd_sink.sv
`timescale 1ns/1ps

// ==========================================================
// reassembly buffer writer model
// ==========================================================
module udtst_cmd_sink
   import udtst_pkg::*;
(
   // clock and reset
   input wire logic                  ref_clk,
   input wire logic                  reset_n,
   // stall control
   input wire logic                  stall,
   // command stream
   input wire logic                  cmdValid,
   output logic                      cmdReady,
   input wire udtst_pkg::udtst_cmd_e cmdCode,
   input wire logic [2:0]            cmdSeq
);
   import udtst_pkg::*;

   udtst_cmd_e gotCode [64];
   logic [2:0] gotSeq [64];
   int         nGot;

   // a stalled writer refuses everything, so the tracker has to hold its words
   assign cmdReady = !stall;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         nGot <= 0;
      else if (cmdValid && cmdReady && nGot < 64)
      begin
         gotCode[nGot] <= cmdCode;
         gotSeq[nGot] <= cmdSeq;
         nGot <= nGot + 1;
      end
   end
endmodule

//--- bench/udtst_tracker_chk.sv
`timescale 1ns/1ps
`include "udtst_regs.svh"

// ==========================================================
// port checker for the sequence tracker
// ==========================================================
module udtst_tracker_chk
   import udtst_pkg::*;
(
   // clock and reset
   input wire logic                    ref_clk,
   input wire logic                    reset_n,
   // control
   input wire logic                    lateCheckEnable,
   input wire logic [`UDTST_TMO_W-1:0] lateTimeout,
   // cell stream
   input wire logic                    cellValid,
   input wire logic                    cellReady,
   input wire logic [`UDTST_SN_W-1:0]  cellSeq,
   input wire logic                    cellSeqOk,
   // commands
   input wire logic                    cmdValid,
   input wire logic                    cmdReady,
   input udtst_pkg::udtst_cmd_e        cmdCode,
   input wire logic [`UDTST_SN_W-1:0]  cmdSeq,
   // events
   input wire logic                    seqErrorEvent,
   input wire logic                    lostCellEvent,
   input wire logic [`UDTST_SN_W-1:0]  lostCount,
   input wire logic                    misinsertEvent,
   input wire logic                    lateCellEvent,
   input udtst_pkg::udtst_state_e      trackState
);
   import udtst_pkg::*;

   logic [2:0] lastSeq_r;
   logic [2:0] lastSeq_nxt;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // last taken number; in locked every taken cell is accepted, so this is the previous cell
   always_comb
   begin
      lastSeq_nxt = lastSeq_r;
      // a misinserted cell in single gap is dropped, so the cell before it stays the previous one
      if (cellValid && cellReady && !(trackState == ST_SINGLE_GAP && cellSeqOk && cellSeq == 3'(lastSeq_r - 3'h1)))
         lastSeq_nxt = cellSeq;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         lastSeq_r <= 3'h0;
      else
         lastSeq_r <= lastSeq_nxt;
   end

   in_seq_a: assert property (cellValid && cellReady && cellSeqOk && trackState == ST_LOCKED
      && cellSeq == lastSeq_r + 3'h1 |=> trackState == ST_LOCKED && !seqErrorEvent)
      else $error("in-sequence cell left locked");
   bad_lock_a: assert property (cellValid && cellReady && !cellSeqOk && trackState == ST_LOCKED
      |=> trackState == ST_SUSPECT)
      else $error("invalid number in locked did not go suspect");
   single_entry_a: assert property (trackState == ST_SINGLE_GAP && $past(trackState) != ST_SINGLE_GAP
      |-> seqErrorEvent && $past(trackState) == ST_LOCKED)
      else $error("single gap entered wrongly");
   gap_entry_a: assert property (trackState == ST_SEQ_GAP && $past(trackState) != ST_SEQ_GAP
      |-> seqErrorEvent && $past(trackState) == ST_LOCKED)
      else $error("sequence gap entered wrongly");
   misinsert_a: assert property (misinsertEvent |-> trackState == ST_LOCKED
      && $past(trackState) inside {ST_SUSPECT, ST_SINGLE_GAP})
      else $error("misinsertion event out of place");
   lost_event_a: assert property (lostCellEvent |-> trackState == ST_LOCKED && lostCount != 3'h0
      && $past(trackState) inside {ST_SEQ_GAP, ST_SINGLE_GAP, ST_LATE_WAIT})
      else $error("lost event out of place");
   hunt_back_a: assert property (cellValid && cellReady && !cellSeqOk
      && trackState inside {ST_SUSPECT, ST_SEQ_GAP} |=> trackState == ST_HUNT)
      else $error("invalid number did not return to hunt");
   late_entry_a: assert property (trackState == ST_LATE_WAIT && $past(trackState) != ST_LATE_WAIT
      |-> $past(trackState) == ST_LOCKED && $past(lateCheckEnable) && !$past(cellValid))
      else $error("late wait entered wrongly");
   late_event_a: assert property (lateCellEvent |-> trackState == ST_LOCKED
      && $past(trackState) == ST_LATE_WAIT)
      else $error("late event out of place");
endmodule

bind udtst_tracker udtst_tracker_chk i_udtst_tracker_chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .lateCheckEnable(lateCheckEnable), .lateTimeout(lateTimeout),
   .cellValid(cellValid), .cellReady(cellReady), .cellSeq(cellSeq), .cellSeqOk(cellSeqOk),
   .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdSeq(cmdSeq),
   .seqErrorEvent(seqErrorEvent), .lostCellEvent(lostCellEvent), .lostCount(lostCount),
   .misinsertEvent(misinsertEvent), .lateCellEvent(lateCellEvent), .trackState(trackState)
);

//--- bench/udtst_tracker_tb.sv
`timescale 1ns/1ps

module udtst_tracker_tb;
   import udtst_pkg::*;

   // ==========================================================
   // signals
   // ==========================================================
   logic         ref_clk, reset_n, lateCheckEnable, cellValid, cellSeqOk, stall;
   logic         cellReady, cmdValid, cmdReady;
   logic         seqErrorEvent, lostCellEvent, misinsertEvent, lateCellEvent;
   logic [2:0]   cellSeq, cmdSeq, lostCount;
   udtst_cmd_e   cmdCode;
   udtst_state_e trackState;
   int           miscompares, nCompared, rdIdx;

   udtst_tracker i_udtst_tracker (.ref_clk(ref_clk), .reset_n(reset_n), .lateCheckEnable(lateCheckEnable),
      .lateTimeout(16'h000a), .cellValid(cellValid), .cellReady(cellReady), .cellSeq(cellSeq),
      .cellSeqOk(cellSeqOk), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdSeq(cmdSeq),
      .seqErrorEvent(seqErrorEvent), .lostCellEvent(lostCellEvent), .lostCount(lostCount),
      .misinsertEvent(misinsertEvent), .lateCellEvent(lateCellEvent), .trackState(trackState));
   udtst_cmd_sink i_udtst_cmd_sink (.ref_clk(ref_clk), .reset_n(reset_n), .stall(stall),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdSeq(cmdSeq));

   // ==========================================================
   // shared tasks
   // ==========================================================
   task finish_test;
      $display("compared %0d mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task stuck(input string what);
      miscompares++;
      $display("[FAIL] %s expected activity seen none", what);
      finish_test();
   endtask

   task chk_val(input string what, input logic [3:0] exp, input logic [3:0] got);
      nCompared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task chk_state(input udtst_state_e exp);
      nCompared++;
      if (trackState !== exp)
      begin
         miscompares++;
         $display("[FAIL] trackState expected %s seen %s", exp.name(), trackState.name());
      end
   endtask

   // waits for the next command at the writer, bounded
   task chk_cmd(input udtst_cmd_e code, input logic [2:0] s);
      int k;
      k = 0;
      while (i_udtst_cmd_sink.nGot <= rdIdx && k < 200)
      begin
         k++;
         @(negedge ref_clk);
      end
      if (k >= 200)
         stuck("command");
      else
      begin
         nCompared++;
         if ({i_udtst_cmd_sink.gotCode[rdIdx], i_udtst_cmd_sink.gotSeq[rdIdx]} !== {code, s})
         begin
            miscompares++;
            $display("[FAIL] command expected %s %h seen %s %h", code.name(), s,
               i_udtst_cmd_sink.gotCode[rdIdx].name(), i_udtst_cmd_sink.gotSeq[rdIdx]);
         end
         rdIdx++;
      end
   endtask

   // offers one cell, then checks the event pulses of the cycle after the take
   task send_cell(input logic [2:0] s, input logic ok, input logic [3:0] expEv);
      int k;
      k = 0;
      @(negedge ref_clk);
      while (cellReady !== 1'b1 && k < 200)
      begin
         k++;
         @(negedge ref_clk);
      end
      if (k >= 200)
         stuck("cellReady");
      else
      begin
         cellValid = 1'b1;
         cellSeq = s;
         cellSeqOk = ok;
         @(negedge ref_clk);
         cellValid = 1'b0;
         chk_val("events", expEv, {seqErrorEvent, lostCellEvent, misinsertEvent, lateCellEvent});
      end
   endtask

   task end_test(input string name, input udtst_state_e st);
      repeat (4) @(negedge ref_clk);
      chk_state(st);
      chk_val("extra commands", 4'h0, 4'(i_udtst_cmd_sink.nGot - rdIdx));
      $display("%s done", name);
   endtask

   // ==========================================================
   // scenarios
   // ==========================================================
   task t_lock;
      send_cell(3'h0, 1'b1, 4'h0);
      send_cell(3'h1, 1'b1, 4'h0);
      send_cell(3'h2, 1'b1, 4'h0);
      chk_cmd(CMD_DISCARD, 3'h0);
      chk_cmd(CMD_ACCEPT, 3'h1);
      chk_cmd(CMD_ACCEPT, 3'h2);
      end_test("lock", ST_LOCKED);
   endtask

   task t_single;
      send_cell(3'h4, 1'b1, 4'h8);
      chk_state(ST_SINGLE_GAP);
      send_cell(3'h5, 1'b1, 4'h4);
      chk_val("lostCount", 4'h1, {1'b0, lostCount});
      chk_cmd(CMD_DUMMY, 3'h3);
      chk_cmd(CMD_ACCEPT, 3'h4);
      chk_cmd(CMD_ACCEPT, 3'h5);
      end_test("single loss", ST_LOCKED);
   endtask

   // writer stalls so the two-entry buffer fills and the rest of the burst of dummies has to wait in the tracker
   task t_multi;
      stall = 1'b1;
      send_cell(3'h2, 1'b1, 4'h8);
      chk_state(ST_SEQ_GAP);
      send_cell(3'h3, 1'b1, 4'h4);
      chk_val("lostCount", 4'h4, {1'b0, lostCount});
      repeat (6) @(negedge ref_clk);
      chk_val("cellReady while full", 4'h0, {3'h0, cellReady});
      stall = 1'b0;
      chk_cmd(CMD_ACCEPT, 3'h2);
      for (int i = 6; i < 10; i++)
         chk_cmd(CMD_DUMMY, 3'(i));
      chk_cmd(CMD_ACCEPT, 3'h3);
      end_test("multiple loss", ST_LOCKED);
   endtask

   task t_suspect;
      send_cell(3'h7, 1'b0, 4'h0);
      chk_state(ST_SUSPECT);
      send_cell(3'h4, 1'b1, 4'h2);
      chk_state(ST_LOCKED);
      send_cell(3'h1, 1'b0, 4'h0);
      send_cell(3'h6, 1'b1, 4'h0);
      chk_cmd(CMD_ACCEPT, 3'h7);
      chk_cmd(CMD_DISCARD, 3'h4);
      chk_cmd(CMD_ACCEPT, 3'h1);
      chk_cmd(CMD_ACCEPT, 3'h6);
      end_test("suspect", ST_LOCKED);
   endtask

   task t_gap;
      send_cell(3'h2, 1'b1, 4'h8);
      send_cell(3'h0, 1'b1, 4'h0);
      chk_state(ST_LOCKED);
      send_cell(3'h3, 1'b1, 4'h8);
      send_cell(3'h5, 1'b0, 4'h0);
      chk_cmd(CMD_ACCEPT, 3'h2);
      chk_cmd(CMD_ACCEPT, 3'h0);
      chk_cmd(CMD_ACCEPT, 3'h3);
      chk_cmd(CMD_DISCARD, 3'h5);
      end_test("gap recovery", ST_HUNT);
   endtask

   task t_acquire;
      send_cell(3'h0, 1'b1, 4'h0);
      send_cell(3'h1, 1'b1, 4'h0);
      send_cell(3'h6, 1'b0, 4'h0);
      send_cell(3'h5, 1'b1, 4'h0);
      chk_cmd(CMD_DISCARD, 3'h0);
      chk_cmd(CMD_ACCEPT, 3'h1);
      chk_cmd(CMD_ACCEPT, 3'h6);
      chk_cmd(CMD_DISCARD, 3'h5);
      end_test("acquiring", ST_ACQUIRING);
   endtask

   task t_late;
      lateCheckEnable = 1'b1;
      end_test("no late insert outside locked", ST_ACQUIRING);
      repeat (16) @(negedge ref_clk);
      chk_val("idle commands", 4'h0, 4'(i_udtst_cmd_sink.nGot - rdIdx));
      lateCheckEnable = 1'b0;
      send_cell(3'h6, 1'b1, 4'h0);
      chk_cmd(CMD_ACCEPT, 3'h6);
      end_test("late check off", ST_LOCKED);
      repeat (30) @(negedge ref_clk);
      chk_state(ST_LOCKED);
      lateCheckEnable = 1'b1;
      chk_cmd(CMD_DUMMY, 3'h7);
      lateCheckEnable = 1'b0;
      chk_state(ST_LATE_WAIT);
      send_cell(3'h7, 1'b1, 4'h1);
      chk_cmd(CMD_DISCARD, 3'h7);
      end_test("late cell", ST_LOCKED);
   endtask

   // ==========================================================
   // clock, reset and main sequence
   // ==========================================================
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial
   begin
      reset_n = 1'b0;
      lateCheckEnable = 1'b0;
      cellValid = 1'b0;
      cellSeq = 3'h0;
      cellSeqOk = 1'b0;
      stall = 1'b0;
      miscompares = 0;
      nCompared = 0;
      rdIdx = 0;
      repeat (16) @(negedge ref_clk);
      reset_n = 1'b1;
      t_lock();
      t_single();
      t_multi();
      t_suspect();
      t_gap();
      t_acquire();
      t_late();
      finish_test();
   end
endmodule

//--- rtl/udtst_pair_buf.sv
`timescale 1ns/1ps
`include "udtst_regs.svh"

module udtst_pair_buf #(
   parameter int WIDTH = 5,
   parameter int DEPTH = `UDTST_BUF_DEPTH
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   import udtst_pkg::*;

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   // ==========================================================
   // storage and pointers
   // ==========================================================
   logic [WIDTH-1:0] mem_r   [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [PW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
   logic [CW-1:0]    count_r, count_nxt;
   logic             doPush, doPop;

   assign inReady  = (count_r != CW'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData  = mem_r[rdPtr_r];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   always_comb
   begin
      mem_nxt   = mem_r;
      wrPtr_nxt = wrPtr_r;
      rdPtr_nxt = rdPtr_r;
      count_nxt = count_r;
      if (doPush)
      begin
         mem_nxt[wrPtr_r] = inData;
         wrPtr_nxt = (wrPtr_r == PW'(DEPTH - 1)) ? '0 : PW'(wrPtr_r + 1'b1);
      end
      if (doPop)
         rdPtr_nxt = (rdPtr_r == PW'(DEPTH - 1)) ? '0 : PW'(rdPtr_r + 1'b1);
      if (doPush && !doPop)
         count_nxt = CW'(count_r + 1'b1);
      else if (doPop && !doPush)
         count_nxt = CW'(count_r - 1'b1);
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_r[i] <= '0;
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         mem_r   <= mem_nxt;
         wrPtr_r <= wrPtr_nxt;
         rdPtr_r <= rdPtr_nxt;
         count_r <= count_nxt;
      end
   end

endmodule

//--- rtl/udtst_pkg.sv
package udtst_pkg;

   // tracker states: hunt, acquiring, locked, suspect, gap, single gap, late wait
   typedef enum {
      ST_HUNT,
      ST_ACQUIRING,
      ST_LOCKED,
      ST_SUSPECT,
      ST_SEQ_GAP,
      ST_SINGLE_GAP,
      ST_LATE_WAIT
   } udtst_state_e;

   // commands to the reassembly buffer writer
   typedef enum logic [1:0] {
      CMD_ACCEPT,
      CMD_DISCARD,
      CMD_DUMMY
   } udtst_cmd_e;

endpackage

//--- rtl/udtst_regs.svh
`ifndef UDTST_REGS_SVH
`define UDTST_REGS_SVH

// ==========================================================
// sequence number and timing widths, lost-count mask, reset values and command buffer depth
// ==========================================================
`define UDTST_SN_W        3
`define UDTST_TMO_W       16
`define UDTST_MAX_LOST    3'h7
`define UDTST_TMO_RST     16'h0000
`define UDTST_SN_RST      3'h0
`define UDTST_BUF_DEPTH   2
`define UDTST_CMD_W       2

`endif

//--- rtl/udtst_tracker.sv
`timescale 1ns/1ps
`include "udtst_regs.svh"
module udtst_tracker (
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     reset_n,
   // control
   input  wire logic                     lateCheckEnable,
   input  wire logic [`UDTST_TMO_W-1:0]  lateTimeout,
   // upstream cell stream
   input  wire logic                     cellValid,
   output logic                          cellReady,
   input  wire logic [`UDTST_SN_W-1:0]   cellSeq,
   input  wire logic                     cellSeqOk,
   // downstream commands
   output logic                          cmdValid,
   input  wire logic                     cmdReady,
   output udtst_pkg::udtst_cmd_e         cmdCode,
   output logic      [`UDTST_SN_W-1:0]   cmdSeq,
   // events
   output logic                          seqErrorEvent,
   output logic                          lostCellEvent,
   output logic      [`UDTST_SN_W-1:0]   lostCount,
   output logic                          misinsertEvent,
   output logic                          lateCellEvent,
   output udtst_pkg::udtst_state_e       trackState
);
   import udtst_pkg::*;
   localparam int SW = `UDTST_SN_W;
   localparam int BW = `UDTST_CMD_W + `UDTST_SN_W;

   // ==========================================================
   // state
   // ==========================================================
   udtst_state_e           state_r, state_nxt;
   logic [SW-1:0]          lastGood_r, lastGood_nxt, lastRx_r, lastRx_nxt;
   logic [SW-1:0]          pendDummy_r, pendDummy_nxt, dummySeq_r, dummySeq_nxt;
   logic                   pendFinal_r, pendFinal_nxt;
   udtst_cmd_e             finalCmd_r, finalCmd_nxt;
   logic [SW-1:0]          finalSeq_r, finalSeq_nxt;
   logic [`UDTST_TMO_W-1:0] tmo_r, tmo_nxt;
   logic                   armed_r, armed_nxt;
   logic                   seqErr_r, seqErr_nxt, lost_r, lost_nxt, misins_r, misins_nxt, late_r, late_nxt;
   logic [SW-1:0]          lostCnt_r, lostCnt_nxt;
   logic                   take, relock, doAccept, lateFire, pushValid, pushReady;
   logic [SW-1:0]          nextGood, twoGood, nextRx;
   logic [BW-1:0]          pushData, popData;
   // cells stall while dummies or the final command still wait for the buffer
   assign cellReady = (pendDummy_r == '0) && !pendFinal_r;
   assign take      = cellValid && cellReady;
   assign nextGood  = SW'(lastGood_r + 1'b1);
   assign twoGood   = SW'(lastGood_r + 2'h2);
   assign nextRx    = SW'(lastRx_r + 1'b1);
   // timer only counts while armed, and arming only happens on entry to locked
   assign lateFire  = (state_r == ST_LOCKED) && armed_r && lateCheckEnable &&
                      (tmo_r >= lateTimeout) && cellReady && !cellValid;
   assign pushValid = (pendDummy_r != '0) || pendFinal_r;
   assign pushData  = (pendDummy_r != '0) ? {CMD_DUMMY, dummySeq_r} : {finalCmd_r, finalSeq_r};
   // ==========================================================
   // sequence decision
   // ==========================================================
   always_comb
   begin
      state_nxt     = state_r;
      lastGood_nxt  = lastGood_r;
      lastRx_nxt    = lastRx_r;
      pendDummy_nxt = pendDummy_r;
      dummySeq_nxt  = dummySeq_r;
      pendFinal_nxt = pendFinal_r;
      finalCmd_nxt  = finalCmd_r;
      finalSeq_nxt  = finalSeq_r;
      tmo_nxt       = tmo_r;
      armed_nxt     = armed_r;
      {seqErr_nxt, lost_nxt, misins_nxt, late_nxt} = 4'h0;
      lostCnt_nxt   = lostCnt_r;
      relock        = 1'b0;
      doAccept      = 1'b0;
      // drain pending commands, dummies always ahead of the cell's own command
      if (pushReady && (pendDummy_r != '0))
      begin
         pendDummy_nxt = SW'(pendDummy_r - 1'b1);
         dummySeq_nxt  = SW'(dummySeq_r + 1'b1);
      end
      else if (pushReady)
         pendFinal_nxt = 1'b0;
      // saturate so a long idle spell cannot wrap and hide the timeout
      if (armed_r && (tmo_r != '1))
         tmo_nxt = `UDTST_TMO_W'(tmo_r + 1'b1);
      // a cell is only taken with nothing pending, so the dummy count starts from zero here
      if (take)
      begin
         lastRx_nxt = cellSeq;
         unique case (state_r)
            ST_HUNT:
               if (cellSeqOk)
                  state_nxt = ST_ACQUIRING;
            ST_ACQUIRING:
               if (!cellSeqOk)
                  state_nxt = ST_HUNT;
               else if (cellSeq == nextRx)
               begin
                  doAccept     = 1'b1;
                  lastGood_nxt = cellSeq;
                  relock       = 1'b1;
               end
            ST_LOCKED:
               if (!cellSeqOk)
               begin
                  doAccept   = 1'b1;
                  lastRx_nxt = lastRx_r;
                  state_nxt  = ST_SUSPECT;
               end
               else if (cellSeq == nextGood)
               begin
                  doAccept     = 1'b1;
                  lastGood_nxt = cellSeq;
                  relock       = 1'b1;
               end
               else if (cellSeq == twoGood)
               begin
                  pendDummy_nxt = 3'h1;
                  doAccept   = 1'b1;
                  seqErr_nxt = 1'b1;
                  state_nxt  = ST_SINGLE_GAP;
               end
               else
               begin
                  doAccept   = 1'b1;
                  seqErr_nxt = 1'b1;
                  state_nxt  = ST_SEQ_GAP;
               end
            ST_SUSPECT, ST_SEQ_GAP:
               if (!cellSeqOk)
                  state_nxt = ST_HUNT;
               else if (state_r == ST_SUSPECT && cellSeq == nextGood)
               begin
                  misins_nxt   = 1'b1;
                  lastGood_nxt = cellSeq;
                  relock       = 1'b1;
               end
               else if (state_r == ST_SEQ_GAP && cellSeq == nextRx)
               begin
                  // gap size is what lies between the last good and last received cell
                  pendDummy_nxt = SW'(lastRx_r - lastGood_r - 1'b1) & `UDTST_MAX_LOST;
                  lostCnt_nxt  = SW'(lastRx_r - lastGood_r - 1'b1);
                  doAccept     = 1'b1;
                  lost_nxt     = 1'b1;
                  lastGood_nxt = cellSeq;
                  relock       = 1'b1;
               end
               else if (cellSeq == twoGood)
               begin
                  doAccept     = 1'b1;
                  lastGood_nxt = cellSeq;
                  relock       = 1'b1;
               end
               else
                  state_nxt = ST_ACQUIRING;
            ST_SINGLE_GAP:
               if (!cellSeqOk)
                  state_nxt = ST_HUNT;
               else if (cellSeq == nextRx)
               begin
                  doAccept     = 1'b1;
                  lost_nxt     = 1'b1;
                  lostCnt_nxt  = 3'h1;
                  lastGood_nxt = cellSeq;
                  relock       = 1'b1;
               end
               else if (cellSeq == nextGood)
               begin
                  // dummy already stood in for the misinserted cell
                  misins_nxt   = 1'b1;
                  lastGood_nxt = lastRx_r;
                  lastRx_nxt   = lastRx_r;
                  relock       = 1'b1;
               end
               else if (cellSeq == twoGood)
               begin
                  lastGood_nxt = cellSeq;
                  relock       = 1'b1;
               end
               else
                  state_nxt = ST_ACQUIRING;
            ST_LATE_WAIT:
               if (!cellSeqOk)
                  state_nxt = ST_HUNT;
               else if (cellSeq == nextGood)
               begin
                  late_nxt     = 1'b1;
                  lastGood_nxt = cellSeq;
                  relock       = 1'b1;
               end
               else if (cellSeq == twoGood)
               begin
                  doAccept     = 1'b1;
                  lost_nxt     = 1'b1;
                  lostCnt_nxt  = 3'h1;
                  seqErr_nxt   = 1'b1;
                  lastGood_nxt = cellSeq;
                  relock       = 1'b1;
               end
               else
               begin
                  seqErr_nxt = 1'b1;
                  state_nxt  = ST_ACQUIRING;
               end
         endcase
         dummySeq_nxt  = nextGood;
         pendFinal_nxt = 1'b1;
         finalCmd_nxt  = doAccept ? CMD_ACCEPT : CMD_DISCARD;
         finalSeq_nxt  = cellSeq;
      end
      else if (lateFire)
      begin
         pendDummy_nxt = 3'h1;
         dummySeq_nxt  = nextGood;
         state_nxt     = ST_LATE_WAIT;
      end
      if (relock)
      begin
         state_nxt = ST_LOCKED;
         armed_nxt = 1'b1;
         tmo_nxt   = `UDTST_TMO_RST;
      end
      else if (state_nxt != ST_LOCKED)
         armed_nxt = 1'b0;
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r     <= ST_HUNT;
         lastGood_r  <= `UDTST_SN_RST;
         lastRx_r    <= `UDTST_SN_RST;
         pendDummy_r <= '0;
         dummySeq_r  <= `UDTST_SN_RST;
         pendFinal_r <= 1'b0;
         finalCmd_r  <= CMD_ACCEPT;
         finalSeq_r  <= `UDTST_SN_RST;
         tmo_r       <= `UDTST_TMO_RST;
         armed_r     <= 1'b0;
         {seqErr_r, lost_r, misins_r, late_r} <= 4'h0;
         lostCnt_r   <= '0;
      end
      else
      begin
         state_r     <= state_nxt;
         lastGood_r  <= lastGood_nxt;
         lastRx_r    <= lastRx_nxt;
         pendDummy_r <= pendDummy_nxt;
         dummySeq_r  <= dummySeq_nxt;
         pendFinal_r <= pendFinal_nxt;
         finalCmd_r  <= finalCmd_nxt;
         finalSeq_r  <= finalSeq_nxt;
         tmo_r       <= tmo_nxt;
         armed_r     <= armed_nxt;
         {seqErr_r, lost_r, misins_r, late_r} <= {seqErr_nxt, lost_nxt, misins_nxt, late_nxt};
         lostCnt_r   <= lostCnt_nxt;
      end
   end

   // ==========================================================
   // command buffer
   // ==========================================================
   // two entries let a full-rate stream pass while the writer stalls for a cycle
   udtst_pair_buf #(
      .WIDTH (BW),
      .DEPTH (`UDTST_BUF_DEPTH)
   ) u_cmd_buf (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .inData   (pushData),
      .outValid (cmdValid),
      .outReady (cmdReady),
      .outData  (popData)
   );
   assign cmdCode        = udtst_cmd_e'(popData[BW-1:SW]);
   assign cmdSeq         = popData[SW-1:0];
   assign {seqErrorEvent, lostCellEvent, misinsertEvent, lateCellEvent} = {seqErr_r, lost_r, misins_r, late_r};
   assign lostCount      = lostCnt_r;
   assign trackState     = state_r;
endmodule
